// ===== inc/result_port_pkg.sv
// Constants and types shared by the result output port
package result_port_pkg;
  // Result and bus geometry
  localparam int RES_W      = 18;
  localparam int PAIR_W     = 2 * RES_W;
  localparam int BUS_W      = 16;
  localparam int BUF_DEPTH  = 2;
  localparam int CNT_W      = 5;
  // Field positions: first pulse carries result bits 17..2, second bits 1..0
  localparam int HI_TOP     = 17;
  localparam int HI_LOW     = 2;
  localparam int LO_TOP     = 1;
  localparam int LO_PAD_W   = 14;
  localparam int SER_LAST   = 17;
  // Pin bundle positions after synchronising
  localparam int PIN_CS     = 0;
  localparam int PIN_RD     = 1;
  localparam int PIN_SEL    = 2;
  localparam int PIN_REF    = 3;
  localparam int PIN_W      = 4;
  // Reset values: strobes idle high, selects low
  localparam logic [3:0]  PIN_RST  = 4'h3;
  localparam logic [15:0] BUS_IDLE = 16'h0000;
  localparam logic [35:0] PAIR_RST = 36'h0_0000_0000;
  // Which channel word of the pair and which half the next pulse shows
  typedef enum logic [1:0] {A_HI, A_LO, B_HI, B_LO} word_phase_t;
endpackage

// ===== sim/host_reader.sv
// Behavioural host that reads result pairs over the parallel bus or serial frames
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  output logic             o_cs_n,
  output logic             o_strobe_n,
  input  wire logic [15:0] i_parallel_bus,
  input  wire logic        i_parallel_oe_n,
  input  wire logic        i_serial_out_first,
  input  wire logic        i_serial_out_second,
  input  wire logic        i_serial_oe_n
);
  // Strobe idles high, chip select idles high
  initial begin
    o_cs_n = 1'b1;
    o_strobe_n = 1'b1;
  end
  // Four strobe pulses per pair, two per channel; 500 ns phases clear the 300 ns floor
  task automatic par_pair(output logic [15:0] w [4], output logic [1:0] oe [4]);
    o_cs_n = 1'b0;
    #200;
    for (int k = 0; k < 4; k++) begin
      o_strobe_n = 1'b0;
      #500;
      w[k] = i_parallel_bus;
      oe[k][0] = i_parallel_oe_n;
      o_strobe_n = 1'b1;
      #500;
      oe[k][1] = i_parallel_oe_n;
    end
    o_cs_n = 1'b1;
    #600;
  endtask
  // Serial frame; the link clock runs at 48 ns only inside the frame
  // Bus bits 9..15 are left to the board, which grounds them in serial mode
  task automatic ser_frame(output logic [17:0] a, output logic [17:0] b, output logic [2:0] oe);
    o_cs_n = 1'b0;
    #30;
    oe[0] = i_serial_oe_n;
    oe[2] = i_parallel_oe_n;
    a[17] = i_serial_out_first;
    b[17] = i_serial_out_second;
    for (int i = 16; i >= 0; i--) begin
      o_strobe_n = 1'b0;
      #24;
      o_strobe_n = 1'b1;
      #24;
      a[i] = i_serial_out_first;
      b[i] = i_serial_out_second;
    end
    o_cs_n = 1'b1;
    #30;
    oe[1] = i_serial_oe_n;
    #570;
  endtask
endmodule // host_reader
`default_nettype wire

// ===== sim/result_output_bus_upper_bits_tb.sv
// Self-checking bench for the result output port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module result_output_bus_upper_bits_tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_interface_select = 1'b0;
  logic        i_ref_select = 1'b0;
  logic        i_result_valid = 1'b0;
  logic [17:0] i_result_a = 18'h00000;
  logic [17:0] i_result_b = 18'h00000;
  wire logic   cs_n, strobe_n, ready, par_oe_n, ser_a, ser_b, ser_oe_n, ref_en;
  wire logic [15:0] bus;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [17:0] ra, rb;
  always #50 i_clk = ~i_clk;
  result_output_bus_upper_bits dut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(strobe_n), .i_cs_n(cs_n),
    .i_rd_n(strobe_n), .i_interface_select(i_interface_select), .i_ref_select(i_ref_select),
    .i_result_valid(i_result_valid), .o_result_ready(ready), .i_result_a(i_result_a), .i_result_b(i_result_b),
    .o_parallel_bus(bus), .o_parallel_oe_n(par_oe_n), .o_serial_out_first(ser_a),
    .o_serial_out_second(ser_b), .o_serial_oe_n(ser_oe_n), .o_int_ref_en(ref_en));
  host_reader host (.o_cs_n(cs_n), .o_strobe_n(strobe_n), .i_parallel_bus(bus), .i_parallel_oe_n(par_oe_n),
    .i_serial_out_first(ser_a), .i_serial_out_second(ser_b), .i_serial_oe_n(ser_oe_n));
  // Hang guard: the whole run needs well under 5000 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR t=%0t timeout", $time);
      report_and_stop();
    end
  end
  // Expected bus word: high half on the first pulse, low bits padded on the second
  function automatic logic [15:0] exp_word(input logic [17:0] r, input logic hi);
    return hi ? r[17:2] : {r[1:0], 14'h0000};
  endfunction
  // Offer a pair and hold it until taken; valid stays high for back-to-back use
  task automatic push(input logic [17:0] a, input logic [17:0] b);
    i_result_a = a;
    i_result_b = b;
    i_result_valid = 1'b1;
    while (ready !== 1'b1) begin
      @(posedge i_clk);
      #2;
    end
    @(posedge i_clk);
    #2;
  endtask
  // Select the mode, let the synchroniser settle, read one pair and compare
  task automatic read_pair(input logic sel, input logic [17:0] a, input logic [17:0] b);
    logic [15:0] w [4];
    logic [1:0]  oe [4];
    logic [17:0] sa, sb;
    logic [2:0]  soe;
    i_interface_select = sel;
    repeat (4) @(posedge i_clk);
    #2;
    if (sel) begin
      host.ser_frame(sa, sb, soe);
      `CHK(sa, a)
      `CHK(sb, b)
      `CHK(soe, 3'b110)
    end else begin
      host.par_pair(w, oe);
      for (int k = 0; k < 4; k++) begin
        `CHK(w[k], exp_word(k < 2 ? a : b, k[0] == 1'b0))
        `CHK(oe[k], 2'b10)
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reference select, buffer fill and stall, both read modes, random pairs
  initial begin
    void'($urandom(32'h1f782bf3));
    repeat (12) @(posedge i_clk);
    #2;
    i_rst = 1'b0;
    repeat (3) @(posedge i_clk);
    #2;
    for (int v = 1; v >= 0; v--) begin
      i_ref_select = v[0];
      repeat (4) @(posedge i_clk);
      #2;
      `CHK(ref_en, v[0])
    end
    push(18'h3ffff, 18'h00000);
    push(18'h20001, 18'h1fffe);
    i_result_a = 18'h15555;
    i_result_b = 18'h2aaaa;
    repeat (3) @(posedge i_clk);
    #2;
    `CHK(ready, 1'b0)
    fork
      push(18'h15555, 18'h2aaaa);
      read_pair(1'b0, 18'h3ffff, 18'h00000);
    join
    i_result_valid = 1'b0;
    read_pair(1'b1, 18'h20001, 18'h1fffe);
    read_pair(1'b0, 18'h15555, 18'h2aaaa);
    read_pair(1'b0, 18'h00000, 18'h00000);
    for (int n = 0; n < 6; n++) begin
      ra = 18'($urandom);
      rb = 18'($urandom);
      push(ra, rb);
      i_result_valid = 1'b0;
      read_pair(1'($urandom), ra, rb);
    end
    report_and_stop();
  end
endmodule // result_output_bus_upper_bits_tb
`default_nettype wire

// ===== verilog/level_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // level_sync
`default_nettype wire

// ===== verilog/pair_buffer.sv
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int W     = 36,
  parameter int DEPTH = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire           push = i_in_valid & o_in_ready;
  wire           pop  = o_out_valid & i_out_ready;

  // Full and empty come from the stored count
  assign o_in_ready  = (cnt_q != CW'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Storage written only on an accepted word
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= ptr_inc(wr_q);
      if (pop) rd_q <= ptr_inc(rd_q);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule // pair_buffer
`default_nettype wire

// ===== verilog/result_output_bus_upper_bits.sv
// Result output port: parallel bus, two serial outputs and reference select
`timescale 1ns/1ps
`default_nettype none
module result_output_bus_upper_bits (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_interface_select,
  input  wire logic        i_ref_select,
  input  wire logic        i_result_valid,
  output logic             o_result_ready,
  input  wire logic [17:0] i_result_a,
  input  wire logic [17:0] i_result_b,
  output logic      [15:0] o_parallel_bus,
  output logic             o_parallel_oe_n,
  output logic             o_serial_out_first,
  output logic             o_serial_out_second,
  output logic             o_serial_oe_n,
  output logic             o_int_ref_en
);
  localparam int RES_W  = result_port_pkg::RES_W;
  localparam int PAIR_W = result_port_pkg::PAIR_W;
  localparam int CNT_W  = result_port_pkg::CNT_W;

  logic [result_port_pkg::PIN_W-1:0] pins_s;
  logic [PAIR_W-1:0]                 head;
  logic                              head_valid;
  logic                              cs_p_q;
  logic                              rd_p_q;
  logic [15:0]                       bus_q;
  logic                              oe_n_q;
  logic                              ref_q;
  logic [PAIR_W-1:0]                 frame_q;
  logic [CNT_W-1:0]                  bit_cnt_q;
  result_port_pkg::word_phase_t      phase_q;
  result_port_pkg::word_phase_t      phase_d;

  // Pin levels come from outside the clock domain
  level_sync #(
    .W       (result_port_pkg::PIN_W),
    .RST_VAL (result_port_pkg::PIN_RST)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_ref_select, i_interface_select, i_rd_n, i_cs_n}),
    .o_sync  (pins_s)
  );

  // Pin decode and strobe edges
  wire cs_s    = pins_s[result_port_pkg::PIN_CS];
  wire rd_s    = pins_s[result_port_pkg::PIN_RD];
  wire ser_s   = pins_s[result_port_pkg::PIN_SEL];
  wire ref_s   = pins_s[result_port_pkg::PIN_REF];
  wire par     = ~ser_s;
  wire rd_rise = ~rd_p_q & rd_s;
  wire cs_rise = ~cs_p_q & cs_s;
  wire drive   = par & ~cs_s & ~rd_s;
  wire step    = par & ~cs_s & rd_rise;
  wire pop_par = step & (phase_q == result_port_pkg::B_LO);
  wire pop_ser = ser_s & cs_rise;
  wire pop     = pop_par | pop_ser;

  // Two-entry buffer: a stall by the reader holds words back from the source
  pair_buffer #(
    .W     (PAIR_W),
    .DEPTH (result_port_pkg::BUF_DEPTH)
  ) u_buf (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_result_valid),
    .o_in_ready  (o_result_ready),
    .i_in_data   ({i_result_a, i_result_b}),
    .o_out_valid (head_valid),
    .i_out_ready (pop),
    .o_out_data  (head)
  );

  // Map one half of one channel word onto the sixteen bus pins
  function automatic logic [15:0] map_word(input result_port_pkg::word_phase_t ph,
                                           input logic [PAIR_W-1:0] pr);
    logic [RES_W-1:0] r;
    r = (ph == result_port_pkg::A_HI || ph == result_port_pkg::A_LO) ? pr[PAIR_W-1:RES_W] : pr[RES_W-1:0];
    if (ph == result_port_pkg::A_HI || ph == result_port_pkg::B_HI) begin
      map_word = r[result_port_pkg::HI_TOP:result_port_pkg::HI_LOW];
    end else begin
      map_word = {r[result_port_pkg::LO_TOP:0], {result_port_pkg::LO_PAD_W{1'b0}}};
    end
  endfunction

  // Empty buffer shows zeros rather than stale data
  wire [PAIR_W-1:0] show  = head_valid ? head : result_port_pkg::PAIR_RST;
  wire [15:0]       bus_d = drive ? map_word(phase_q, show) : result_port_pkg::BUS_IDLE;

  // Next word half: restart at each new chip select, advance per pulse
  always_comb begin
    phase_d = phase_q;
    if (cs_s) begin
      phase_d = result_port_pkg::A_HI;
    end else if (step) begin
      unique case (phase_q)
        result_port_pkg::A_HI: phase_d = result_port_pkg::A_LO;
        result_port_pkg::A_LO: phase_d = result_port_pkg::B_HI;
        result_port_pkg::B_HI: phase_d = result_port_pkg::B_LO;
        result_port_pkg::B_LO: phase_d = result_port_pkg::A_HI;
      endcase
    end
  end

  // Strobe history and word phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_p_q  <= 1'b1;
      rd_p_q  <= 1'b1;
      phase_q <= result_port_pkg::A_HI;
    end else begin
      cs_p_q  <= cs_s;
      rd_p_q  <= rd_s;
      phase_q <= phase_d;
    end
  end

  // Bus drivers float again as soon as either strobe is seen high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_q  <= result_port_pkg::BUS_IDLE;
      oe_n_q <= 1'b1;
      ref_q  <= 1'b0;
    end else begin
      bus_q  <= bus_d;
      oe_n_q <= ~drive;
      ref_q  <= ref_s;
    end
  end

  // Frame word is frozen while chip select is low, so the link side may read it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_q <= result_port_pkg::PAIR_RST;
    end else if (cs_s) begin
      frame_q <= show;
    end
  end

  // Link side: bit counter cleared while the frame is closed
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != CNT_W'(result_port_pkg::SER_LAST)) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  // Serial bit picks: MSB at count zero, later bits after each clock rise
  wire [5:0] idx_a = 6'(PAIR_W - 1) - {1'b0, bit_cnt_q};
  wire [5:0] idx_b = 6'(RES_W - 1) - {1'b0, bit_cnt_q};

  assign o_parallel_bus      = bus_q;
  assign o_parallel_oe_n     = oe_n_q;
  assign o_int_ref_en        = ref_q;
  // Serial pins follow the frame pin directly; a resampled enable would miss the MSB
  assign o_serial_out_first  = frame_q[idx_a];
  assign o_serial_out_second = frame_q[idx_b];
  assign o_serial_oe_n       = i_cs_n | ~ser_s;

  // Checks on the system clock
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wire [RES_W-1:0] word_a = show[PAIR_W-1:RES_W];
  wire [RES_W-1:0] word_b = show[RES_W-1:0];

  a_float_on_cs: assert property (cs_s |=> o_parallel_oe_n)
    else $error("parallel bus driven while chip select high");
  a_drive_cause: assert property (!o_parallel_oe_n |-> $past(par & ~cs_s & ~rd_s))
    else $error("parallel bus driven without both strobes low");
  a_db7_db8: assert property (drive && phase_q == result_port_pkg::A_HI |=>
      o_parallel_bus[8:7] == $past(word_a[10:9]))
    else $error("bus bits 8..7 do not carry result bits 10..9");
  a_hi_field: assert property (drive && phase_q == result_port_pkg::A_HI |=>
      o_parallel_bus[13:9] == $past(word_a[15:11]) && o_parallel_bus[6:0] == $past(word_a[8:2]))
    else $error("first pulse field mismatch");
  a_lo_zeros: assert property (drive && phase_q == result_port_pkg::A_LO |=>
      o_parallel_bus[13:0] == 14'h0000)
    else $error("second pulse not zero below bit 14");
  a_top_bits: assert property (drive && phase_q == result_port_pkg::A_LO |=>
      o_parallel_bus[15:14] == $past(word_a[1:0]))
    else $error("second pulse top bits wrong");
  a_top_first: assert property (drive && phase_q == result_port_pkg::A_HI |=>
      o_parallel_bus[15:14] == $past(word_a[17:16]))
    else $error("first pulse top bits wrong");
  a_phase_step: assert property (step && phase_q == result_port_pkg::A_HI |=>
      phase_q == result_port_pkg::A_LO ##1 (phase_q == result_port_pkg::A_LO || cs_s))
    else $error("word phase did not advance");
  a_serial_quiet: assert property (ser_s [*2] |-> o_parallel_oe_n)
    else $error("parallel bus driven in serial mode");
  a_ref_follow: assert property ($rose(ref_s) |=> o_int_ref_en [*2])
    else $error("internal reference enable not following select");
  a_ref_off: assert property ($fell(ref_s) |=> !o_int_ref_en)
    else $error("internal reference enable stuck high");

  // Channel B halves use the same layout as channel A
  a_b_hi_word: assert property (drive && phase_q == result_port_pkg::B_HI |=>
      o_parallel_bus == $past(word_b[17:2]))
    else $error("channel B first pulse mismatch");
  a_b_lo_word: assert property (drive && phase_q == result_port_pkg::B_LO |=>
      o_parallel_bus == {$past(word_b[1:0]), 14'h0000})
    else $error("channel B second pulse mismatch");

  // Strobe release and the walk through the four halves
  a_float_on_rd: assert property (rd_s |=> o_parallel_oe_n)
    else $error("parallel bus driven while read strobe high");
  a_drive_oe: assert property (drive |=> !o_parallel_oe_n)
    else $error("parallel bus not driven with both strobes low");
  a_idle_bus: assert property (o_parallel_oe_n |-> o_parallel_bus == 16'h0000)
    else $error("bus holds data while floating");
  a_phase_reset: assert property (cs_s |=> phase_q == result_port_pkg::A_HI)
    else $error("word phase not restarted by chip select");
  a_phase_b: assert property (step && phase_q == result_port_pkg::A_LO |=> phase_q == result_port_pkg::B_HI)
    else $error("word phase did not reach channel B");
  a_phase_b_lo: assert property (step && phase_q == result_port_pkg::B_HI |=> phase_q == result_port_pkg::B_LO)
    else $error("word phase did not reach channel B low half");
  a_phase_wrap: assert property (step && phase_q == result_port_pkg::B_LO |=> phase_q == result_port_pkg::A_HI)
    else $error("word phase did not wrap");

  // Serial side: parallel pins quiet, frame word frozen during a frame
  a_serial_zero: assert property (ser_s [*2] |-> o_parallel_bus == 16'h0000)
    else $error("parallel data shown in serial mode");
  a_ser_oe_par: assert property (!ser_s |-> o_serial_oe_n)
    else $error("serial outputs driven in parallel mode");
  a_frame_hold: assert property (!cs_s |=> $stable(frame_q))
    else $error("frame word changed inside a frame");

  c_par_read: cover property (step && phase_q == result_port_pkg::B_LO);
  c_ser_frame: cover property (pop_ser && head_valid);
  c_buf_full: cover property (!o_result_ready && i_result_valid);
  c_empty_read: cover property (drive && !head_valid);
  c_ref_on: cover property ($rose(o_int_ref_en));
endmodule // result_output_bus_upper_bits
`default_nettype wire
